/* File: hw/mmd_pkg.sv */
// Constants, address map and types shared by the memory map decoder.
// Assumes byte addresses of 24 bits and a 100 MHz core clock.
package mmd_pkg;
   // Masters, in fixed priority order (lowest index wins)
   localparam int NM = 5;
   localparam int M_PROG = 0;
   localparam int M_DRD = 1;
   localparam int M_DWR = 2;
   localparam int M_DMA = 3;
   localparam int M_USB = 4;
   // Widths and on-chip RAM shape: 32 blocks of 2048 x 32 (4K x 16)
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam int LANE_W = 16;
   localparam int ROW_W = 11;
   localparam int BLK_W = 5;
   localparam int NBLK = 32;
   localparam int NROW = 2048;
   localparam int EXT_AW = 21;
   localparam int N_CS_ASYNC = 4;
   localparam logic [BLK_W-1:0] N_DUAL_BLK = 5'h08;
   localparam logic [2:0] CAP_DUAL = 3'h2;
   localparam logic [2:0] CAP_SINGLE = 3'h1;
   // Core-side byte map
   localparam logic [ADDR_W-1:0] DUAL_TOP = 24'h00_FFFF;
   localparam logic [ADDR_W-1:0] MMR_TOP = 24'h00_00BF;
   localparam logic [ADDR_W-1:0] SING_BASE = 24'h01_0000;
   localparam logic [ADDR_W-1:0] SING_TOP = 24'h03_FFFF;
   localparam logic [ADDR_W-1:0] EXT_BASE = 24'h05_0000;
   localparam logic [ADDR_W-1:0] ROM_BASE = 24'hFE_0000;
   // DMA/USB-side byte map
   localparam logic [ADDR_W-1:0] DMA_DUAL_LO = 24'h01_0000;
   localparam logic [ADDR_W-1:0] DMA_DUAL_HI = 24'h01_FFFF;
   localparam logic [ADDR_W-1:0] DMA_DUAL_OFS = 24'h01_0000;
   localparam logic [ADDR_W-1:0] DMA_SING_LO = 24'h09_0000;
   localparam logic [ADDR_W-1:0] DMA_SING_HI = 24'h0B_FFFF;
   localparam logic [ADDR_W-1:0] DMA_SING_OFS = 24'h08_0000;
   // External chip-select space bases
   localparam logic [ADDR_W-1:0] CS2_BASE = 24'h80_0000;
   localparam logic [ADDR_W-1:0] CS3_BASE = 24'hC0_0000;
   localparam logic [ADDR_W-1:0] CS4_BASE = 24'hE0_0000;
   localparam logic [ADDR_W-1:0] CS5_BASE = 24'hF0_0000;
   // Target of one access
   typedef enum logic [5:0] {
      TGT_NONE = 6'h01,
      TGT_RAM = 6'h02,
      TGT_MMR = 6'h04,
      TGT_ROM = 6'h08,
      TGT_EXT = 6'h10,
      TGT_IO = 6'h20
   } mmd_tgt_t;
endpackage

/* File: hw/mmd_ram_if.sv */
// One access port of an on-chip RAM block.
// Assumes the controller drives it from the core clock domain.
`timescale 1ns/1ns
interface mmd_ram_if;
   logic en;
   logic we;
   logic [1:0] lane_en;
   logic [10:0] row;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport ctrl(output en, we, lane_en, row, wdata, input rdata);
   modport ram(input en, we, lane_en, row, wdata, output rdata);
endinterface

/* File: hw/mmd_ram_bank.sv */
// One on-chip RAM block of 4K x 16 held as 2048 x 32.
// Assumes the decoder never grants more ports than the block has.
`timescale 1ns/1ns
module mmd_ram_bank import mmd_pkg::*; #(
   parameter bit DUAL = 1'b1
) (
   // Clock
   input wire logic sys_clk,
   // Access ports
   mmd_ram_if.ram pa,
   mmd_ram_if.ram pb
);
   logic [DATA_W-1:0] mem [NROW];

   ////////////////////////////////////////////////////////////////////////
   // Read is combinational; the decoder registers the result
   assign pa.rdata = mem[pa.row];
   assign pb.rdata = DUAL ? mem[pb.row] : 32'h0000_0000;

   // Two writes to one lane of one row: port b lands last and wins
   always_ff @(posedge sys_clk) begin
      for (int l = 0; l < 2; l++) begin
         if (pa.en && pa.we && pa.lane_en[l]) begin
            mem[pa.row][l*LANE_W +: LANE_W] <= pa.wdata[l*LANE_W +: LANE_W];
         end
         if (DUAL && pb.en && pb.we && pb.lane_en[l]) begin
            mem[pb.row][l*LANE_W +: LANE_W] <= pb.wdata[l*LANE_W +: LANE_W];
         end
      end
   end
endmodule // mmd_ram_bank

/* File: hw/mmd_memory_map_decoder.sv */
// Memory map decoder: steers core, DMA and USB accesses to on-chip RAM,
// and to one shared port for mapped registers, ROM, I/O and external
// memory. Assumes all masters and the shared port run on sys_clk and
// hold a stalled request steady until it is taken.
`timescale 1ns/1ns

// How it works
// - Core bytes 0x0000-0xFFFF hit dual-port RAM, eight 8 KB blocks.
// - A dual-port block takes two accesses in one cycle, any mix.
// - Program, data and DMA buses all reach dual-port RAM.
// - DMA sees dual-port RAM at core address plus 0x10000.
// - Lowest 192 core bytes go to core-mapped registers, not RAM.
// - Core bytes 0x10000-0x3FFFF hit single-port RAM, 24 blocks.
// - A single-port block takes only one access per cycle.
// - All buses reach single-port RAM; DMA/USB add 0x80000.
// - Core 0x40000-0x4FFFF and DMA 0xC0000-0xCFFFF are empty.
// - Top 128 KB is ROM, one word per cycle.
// - ROM is mapped while the disable bit is low, else unmapped.
// - Hardware reset clears the ROM disable bit.
// - Software reset leaves the ROM disable bit alone.
// - ROM is reachable from program and data buses only.
// - Bytes from 0x50000 up to the ROM go external, in five chip-select spaces.
// - First space is SDRAM, optionally with a paired select; rest async.
// - A space's chip select is asserted for each access to it.
// - External port has 8/16-bit data, 21-bit address, six selects.
// - I/O space accesses are kept apart from program/data space.
// - DMA moves a full 32-bit word per cycle beside core accesses.
// - Unmapped reads return zero and unmapped writes are dropped.
// - The USB master has no path to dual-port RAM.
module mmd_memory_map_decoder import mmd_pkg::*; (
   // Clock and resets
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic soft_rst,
   // Master requests, index 0 has highest priority
   input wire logic [NM-1:0] m_req,
   input wire logic [NM-1:0] m_we,
   input wire logic [NM-1:0] m_dbl,
   input wire logic [NM-1:0] m_io,
   input wire logic [ADDR_W-1:0] m_addr [NM],
   input wire logic [DATA_W-1:0] m_wdata [NM],
   // Master answers
   output logic [NM-1:0] m_stall,
   output logic [NM-1:0] m_rvalid,
   output logic [DATA_W-1:0] m_rdata [NM],
   // Status word control of the ROM disable bit
   input wire logic cpu_status_word_three_we,
   input wire logic rom_disable_bit_in,
   output logic rom_disable_bit,
   // Shared port to registers, ROM, I/O and external memory
   output logic xp_req,
   output logic xp_we,
   output logic xp_dbl,
   output logic [5:0] xp_tgt,
   output logic [ADDR_W-1:0] xp_addr,
   output logic [DATA_W-1:0] xp_wdata,
   input wire logic [DATA_W-1:0] xp_rdata,
   // External memory port controls and pins
   input wire logic sdram_pair_mode,
   input wire logic ext_bus_8bit,
   output logic [EXT_AW-1:0] ext_addr,
   output logic sdram_region_select_n,
   output logic sdram_pair_select_n,
   output logic [N_CS_ASYNC-1:0] ext_region_select_n
);
   mmd_tgt_t tgt [NM];
   logic [ADDR_W-1:0] off [NM];
   logic [BLK_W-1:0] blk [NM];
   logic [2:0] rank [NM];
   logic [NM-1:0] ram_go;
   logic [NM-1:0] xp_want;
   logic [NM-1:0] xp_go;
   logic [NM-1:0] accept;
   logic [2:0] xp_sel;
   logic [DATA_W-1:0] rd_a [NBLK];
   logic [DATA_W-1:0] rd_b [NBLK];
   logic [DATA_W-1:0] ram_rd [NM];
   logic [NM-1:0] pend_q;
   logic [NM-1:0] pend_we_q;
   logic [NM-1:0] pend_dbl_q;
   logic [NM-1:0] rvalid_q;
   logic [DATA_W-1:0] rdata_q [NM];
   logic rom_dis_q;
   logic xp_req_q;
   logic xp_we_q;
   logic xp_dbl_q;
   mmd_tgt_t xp_tgt_q;
   logic [ADDR_W-1:0] xp_addr_q;
   logic [DATA_W-1:0] xp_wdata_q;
   logic [EXT_AW-1:0] ext_addr_q;
   logic cs_sdram_q;
   logic cs_pair_q;
   logic [N_CS_ASYNC-1:0] cs_async_q;

   ////////////////////////////////////////////////////////////////////////
   // Per-master address decode into a target and a core-side offset
   for (genvar g = 0; g < NM; g++) begin : g_dec
      localparam bit CORE = (g < M_DMA);
      localparam bit USB = (g == M_USB);
      logic [ADDR_W-1:0] a;
      logic in_dual_c;
      logic in_mmr;
      logic in_sing_c;
      logic in_rom;
      logic in_ext;
      logic in_dual_d;
      logic in_sing_d;
      logic ram_hit;
      assign a = m_addr[g];
      assign in_dual_c = (a <= DUAL_TOP);
      assign in_mmr = (a <= MMR_TOP);
      assign in_sing_c = (a >= SING_BASE) && (a <= SING_TOP);
      // Disabled ROM leaves a hole, it does not fall through to external
      assign in_rom = (a >= ROM_BASE) && !rom_dis_q;
      assign in_ext = (a >= EXT_BASE) && (a < ROM_BASE);
      // USB gets no dual-port window at all
      assign in_dual_d = !USB && (a >= DMA_DUAL_LO) &&
                         (a <= DMA_DUAL_HI);
      assign in_sing_d = (a >= DMA_SING_LO) && (a <= DMA_SING_HI);
      // Reserved windows simply match nothing below
      assign ram_hit = CORE ? ((in_dual_c && !in_mmr) || in_sing_c)
                            : (in_dual_d || in_sing_d);
      assign tgt[g] = m_io[g] ? TGT_IO :
                      ram_hit ? TGT_RAM :
                      (CORE && in_mmr) ? TGT_MMR :
                      (CORE && in_rom) ? TGT_ROM :
                      (CORE && in_ext) ? TGT_EXT : TGT_NONE;
      assign off[g] = CORE ? a : in_dual_d ? a - DMA_DUAL_OFS
                                           : a - DMA_SING_OFS;
      assign blk[g] = off[g][17:13];
      assign xp_want[g] = m_req[g] && !pend_q[g] &&
                          (tgt[g] != TGT_RAM) && (tgt[g] != TGT_NONE);
   end

   ////////////////////////////////////////////////////////////////////////
   // Rank of each RAM request among higher-priority hits on its block
   always_comb begin
      for (int g = 0; g < NM; g++) begin
         rank[g] = 3'h0;
         for (int h = 0; h < g; h++) begin
            if (m_req[h] && !pend_q[h] && (tgt[h] == TGT_RAM) &&
                (blk[h] == blk[g])) begin
               rank[g] = rank[g] + 3'h1;
            end
         end
         // Dual blocks serve two, single blocks one
         ram_go[g] = m_req[g] && !pend_q[g] && (tgt[g] == TGT_RAM) &&
                     (rank[g] < (blk[g] < N_DUAL_BLK ? CAP_DUAL
                                 : CAP_SINGLE));
      end
   end

   // Shared port takes the highest-priority requester each cycle
   always_comb begin
      xp_sel = 3'h0;
      for (int g = NM - 1; g >= 0; g--) begin
         if (xp_want[g]) begin
            xp_sel = 3'(g);
         end
      end
   end

   for (genvar g = 0; g < NM; g++) begin : g_go
      assign xp_go[g] = xp_want[g] && (xp_sel == 3'(g));
      // Losers stall; a master also waits out its own shared-port access
      assign m_stall[g] = m_req[g] && (pend_q[g] ||
                          ((tgt[g] == TGT_RAM) && !ram_go[g]) ||
                          (xp_want[g] && !xp_go[g]));
      assign accept[g] = m_req[g] && !m_stall[g];
      assign ram_rd[g] = (rank[g] == 3'h0) ? rd_a[blk[g]] : rd_b[blk[g]];
   end

   ////////////////////////////////////////////////////////////////////////
   // RAM blocks: rank 0 lands on port a, rank 1 on port b
   mmd_ram_if pa_if [NBLK] ();
   mmd_ram_if pb_if [NBLK] ();

   for (genvar b = 0; b < NBLK; b++) begin : g_blk
      logic [1:0] en;
      logic [1:0] we;
      logic [1:0] lane [2];
      logic [ROW_W-1:0] row [2];
      logic [DATA_W-1:0] wd [2];
      always_comb begin
         en = 2'h0;
         we = 2'h0;
         for (int p = 0; p < 2; p++) begin
            lane[p] = 2'h0;
            row[p] = '0;
            wd[p] = '0;
         end
         for (int m = 0; m < NM; m++) begin
            if (ram_go[m] && (blk[m] == 5'(b))) begin
               en[rank[m][0]] = 1'b1;
               we[rank[m][0]] = m_we[m];
               row[rank[m][0]] = off[m][12:2];
               // Wide access fills both lanes of one row in one cycle
               lane[rank[m][0]] = m_dbl[m] ? 2'h3 :
                                  (off[m][1] ? 2'h2 : 2'h1);
               wd[rank[m][0]] = m_dbl[m] ? m_wdata[m] :
                                {m_wdata[m][15:0], m_wdata[m][15:0]};
            end
         end
      end
      assign pa_if[b].en = en[0];
      assign pa_if[b].we = we[0];
      assign pa_if[b].lane_en = lane[0];
      assign pa_if[b].row = row[0];
      assign pa_if[b].wdata = wd[0];
      assign pb_if[b].en = en[1];
      assign pb_if[b].we = we[1];
      assign pb_if[b].lane_en = lane[1];
      assign pb_if[b].row = row[1];
      assign pb_if[b].wdata = wd[1];
      assign rd_a[b] = pa_if[b].rdata;
      assign rd_b[b] = pb_if[b].rdata;
      mmd_ram_bank #(
         .DUAL(b < 8)
      ) u_bank (
         .sys_clk(sys_clk),
         .pa(pa_if[b]),
         .pb(pb_if[b])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Answers: RAM and unmapped reads next cycle, shared port one later
   always_ff @(posedge sys_clk) begin
      if (rst || soft_rst) begin
         pend_q <= '0;
         pend_we_q <= '0;
         pend_dbl_q <= '0;
         rvalid_q <= '0;
         for (int g = 0; g < NM; g++) begin
            rdata_q[g] <= 32'h0000_0000;
         end
      end else begin
         for (int g = 0; g < NM; g++) begin
            pend_q[g] <= xp_go[g];
            pend_we_q[g] <= m_we[g];
            pend_dbl_q[g] <= m_dbl[g];
            rvalid_q[g] <= (accept[g] && !m_we[g] && !xp_go[g]) ||
                           (pend_q[g] && !pend_we_q[g]);
            if (pend_q[g]) begin
               rdata_q[g] <= pend_dbl_q[g] ? xp_rdata
                                           : {16'h0000, xp_rdata[15:0]};
            end else if (accept[g] && (tgt[g] == TGT_RAM)) begin
               rdata_q[g] <= m_dbl[g] ? ram_rd[g] :
                             (off[g][1] ? {16'h0000, ram_rd[g][31:16]}
                                        : {16'h0000, ram_rd[g][15:0]});
            end else begin
               rdata_q[g] <= 32'h0000_0000;
            end
         end
      end
   end

   assign m_rvalid = rvalid_q;
   assign m_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // ROM disable bit: of the two resets, only the hardware reset clears it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rom_dis_q <= 1'b0;
      end else if (cpu_status_word_three_we) begin
         rom_dis_q <= rom_disable_bit_in;
      end
   end

   assign rom_disable_bit = rom_dis_q;

   ////////////////////////////////////////////////////////////////////////
   // Chip-select space of the shared-port winner
   logic [ADDR_W-1:0] xa;
   logic [ADDR_W-1:0] cs_base;
   logic [ADDR_W-1:0] cs_off;
   logic [N_CS_ASYNC-1:0] cs_async;
   logic is_ext;
   assign xa = m_addr[xp_sel];
   assign is_ext = (xp_want != '0) && (tgt[xp_sel] == TGT_EXT);
   assign cs_async[0] = (xa >= CS2_BASE) && (xa < CS3_BASE);
   assign cs_async[1] = (xa >= CS3_BASE) && (xa < CS4_BASE);
   assign cs_async[2] = (xa >= CS4_BASE) && (xa < CS5_BASE);
   assign cs_async[3] = (xa >= CS5_BASE);
   assign cs_base = cs_async[3] ? CS5_BASE : cs_async[2] ? CS4_BASE :
                    cs_async[1] ? CS3_BASE : cs_async[0] ? CS2_BASE
                                                         : EXT_BASE;
   assign cs_off = xa - cs_base;

   // Shared port and pins are registered so the pads see clean edges
   always_ff @(posedge sys_clk) begin
      if (rst || soft_rst) begin
         xp_req_q <= 1'b0;
         xp_we_q <= 1'b0;
         xp_dbl_q <= 1'b0;
         xp_tgt_q <= TGT_NONE;
         xp_addr_q <= '0;
         xp_wdata_q <= '0;
         ext_addr_q <= '0;
         cs_sdram_q <= 1'b0;
         cs_pair_q <= 1'b0;
         cs_async_q <= '0;
      end else begin
         xp_req_q <= (xp_want != '0);
         xp_we_q <= m_we[xp_sel];
         xp_dbl_q <= m_dbl[xp_sel];
         xp_tgt_q <= tgt[xp_sel];
         xp_addr_q <= xa;
         xp_wdata_q <= m_wdata[xp_sel];
         // Byte address on an 8-bit bus, word address on a 16-bit bus
         ext_addr_q <= ext_bus_8bit ? cs_off[20:0] : cs_off[21:1];
         cs_sdram_q <= is_ext && (cs_async == '0);
         cs_pair_q <= is_ext && (cs_async == '0) && sdram_pair_mode;
         cs_async_q <= is_ext ? cs_async : '0;
      end
   end

   assign xp_req = xp_req_q;
   assign xp_we = xp_we_q;
   assign xp_dbl = xp_dbl_q;
   assign xp_tgt = xp_tgt_q;
   assign xp_addr = xp_addr_q;
   assign xp_wdata = xp_wdata_q;
   assign ext_addr = ext_addr_q;
   assign sdram_region_select_n = !cs_sdram_q;
   assign sdram_pair_select_n = !cs_pair_q;
   assign ext_region_select_n = ~cs_async_q;
endmodule // mmd_memory_map_decoder

/* File: verification/mmd_memory_map_decoder_properties.sv */
// Checker for the memory map decoder: answer timing, decode and grants.
// Assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/1ns
module mmd_map_props import mmd_pkg::*; (
   // Clock and resets
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic soft_rst,
   // Masters
   input wire logic [NM-1:0] m_req,
   input wire logic [NM-1:0] m_we,
   input wire logic [NM-1:0] m_dbl,
   input wire logic [NM-1:0] m_io,
   input wire logic [ADDR_W-1:0] m_addr [NM],
   input wire logic [NM-1:0] m_stall,
   input wire logic [NM-1:0] m_rvalid,
   input wire logic [DATA_W-1:0] m_rdata [NM],
   // Status bit
   input wire logic cpu_status_word_three_we,
   input wire logic rom_disable_bit_in,
   input wire logic rom_disable_bit,
   // Shared port and selects
   input wire logic xp_req,
   input wire logic [DATA_W-1:0] xp_rdata,
   input wire logic sdram_region_select_n,
   input wire logic [N_CS_ASYNC-1:0] ext_region_select_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   // Taken reads; pairs only count while the shared port is quiet,
   // since its follow-up cycle stalls the master that made the access
   wire logic [ADDR_W-1:0] a_rd = m_addr[1];
   wire logic [ADDR_W-1:0] a_dma = m_addr[3];
   wire logic [ADDR_W-1:0] a_usb = m_addr[4];
   wire logic rd_ok = m_req[1] && !m_stall[1] && !m_we[1] && !m_io[1]
      && !soft_rst;
   wire logic usb_rd = m_req[4] && !m_stall[4] && !m_we[4] && !m_io[4]
      && !soft_rst;
   wire logic pair = m_req == 5'h0A && !m_io[1] && !m_io[3] && !xp_req
      && !soft_rst;
   wire logic dual_hit = a_rd > MMR_TOP && a_rd <= DUAL_TOP
      && a_dma[23:13] == {8'h01, a_rd[15:13]};
   wire logic sing_hit = a_dma >= DMA_SING_LO && a_dma <= DMA_SING_HI
      && a_rd >= SING_BASE && a_rd <= SING_TOP
      && a_dma[23:13] - 11'h040 == a_rd[23:13];
   sequence rom_rd;
      rd_ok && m_dbl[1] && a_rd >= ROM_BASE && !rom_disable_bit;
   endsequence
   sequence xp_answer;
      xp_req ##1 (m_rvalid[1] && m_rdata[1] == $past(xp_rdata));
   endsequence

   reset_clears_a: assert property (disable iff (1'b0)
      rst |=> !m_rvalid && !xp_req && !rom_disable_bit)
      else $error("reset left an answer or the ROM bit set");
   soft_keeps_rom_a: assert property (
      soft_rst && !cpu_status_word_three_we |=> $stable(rom_disable_bit))
      else $error("soft reset changed the ROM bit");
   rom_bit_load_a: assert property (
      cpu_status_word_three_we
      |=> rom_disable_bit == $past(rom_disable_bit_in))
      else $error("ROM bit not loaded");
   ram_read_next_a: assert property (
      rd_ok && a_rd > MMR_TOP && a_rd <= SING_TOP |=> m_rvalid[1])
      else $error("RAM read not answered next cycle");
   reserved_zero_a: assert property (
      rd_ok && a_rd >= 24'h04_0000 && a_rd < EXT_BASE
      |=> m_rvalid[1] && m_rdata[1] == '0)
      else $error("reserved read not zero");
   usb_no_dual_a: assert property (
      usb_rd && a_usb >= DMA_DUAL_LO && a_usb <= DMA_DUAL_HI
      |=> m_rvalid[4] && m_rdata[4] == '0)
      else $error("USB reached dual RAM");
   rom_removed_a: assert property (
      rd_ok && rom_disable_bit && a_rd >= ROM_BASE
      |=> m_rvalid[1] && m_rdata[1] == '0)
      else $error("disabled ROM still answers");
   rom_read_path_a: assert property (rom_rd |=> xp_answer)
      else $error("ROM read path wrong");
   sdram_select_a: assert property (
      rd_ok && a_rd >= EXT_BASE && a_rd < CS2_BASE
      |=> xp_req && !sdram_region_select_n && &ext_region_select_n)
      else $error("SDRAM select wrong");
   top_select_a: assert property (
      rd_ok && a_rd >= CS5_BASE && a_rd < ROM_BASE
      |=> xp_req && ext_region_select_n == 4'h7 && sdram_region_select_n)
      else $error("last async select wrong");
   dual_both_a: assert property (pair && dual_hit
      |-> !m_stall[1] && !m_stall[3])
      else $error("dual block refused a second access");
   single_one_a: assert property (pair && sing_hit
      |-> m_stall[3])
      else $error("single block granted twice");
endmodule // mmd_map_props

bind mmd_memory_map_decoder mmd_map_props i_props (.sys_clk, .rst,
   .soft_rst, .m_req, .m_we, .m_dbl, .m_io, .m_addr, .m_stall, .m_rvalid,
   .m_rdata, .cpu_status_word_three_we, .rom_disable_bit_in,
   .rom_disable_bit, .xp_req, .xp_rdata, .sdram_region_select_n,
   .ext_region_select_n);

/* File: verification/mmd_xp_model.sv */
// Model of the targets behind the shared port (registers, ROM, I/O,
// external memory). Assumes it answers in the cycle of xp_req.
`timescale 1ns/1ns
module mmd_xp_model import mmd_pkg::*; (
   // Clock
   input wire logic sys_clk,
   // Shared port
   input wire logic xp_req,
   input wire logic [5:0] xp_tgt,
   output logic [DATA_W-1:0] xp_rdata
);
   logic flip_q = 1'b0;
   // Idle pattern changes every cycle so stale data never looks valid
   always_ff @(posedge sys_clk) begin
      flip_q <= !flip_q;
   end
   // One word per cycle, tagged with the target that was asked
   assign xp_rdata = xp_req ? {8'h5A, 18'h0, xp_tgt} : {32{flip_q}};
endmodule // mmd_xp_model

/* File: verification/test_memory_map_decoder.sv */
// Testbench for the memory map decoder: drives the masters, notes
// expected reads per master and compares them as answers appear.
// Assumes the shared-port model answers in the request cycle.
`timescale 1ns/1ns
module test_memory_map_decoder import mmd_pkg::*;;
   logic sys_clk = 1'b0;
   logic rst, soft_rst, swe, rin, pair, bus8, rbit, sd_n, pr_n;
   logic xp_req;
   logic [NM-1:0] m_req, m_we, m_dbl, m_io, m_stall, m_rvalid;
   logic [ADDR_W-1:0] m_addr [NM];
   logic [DATA_W-1:0] m_wdata [NM];
   logic [DATA_W-1:0] m_rdata [NM];
   logic [DATA_W-1:0] xp_rdata, d;
   logic [5:0] xp_tgt;
   logic [3:0] cs_n;
   logic [EXT_AW-1:0] ext_a;
   logic [ADDR_W-1:0] a, xp_a;
   logic [DATA_W-1:0] eq [NM][$];
   int n_fail = 0;
   int checks = 0;
   int seed = 2159;
   int xm;
   logic [ADDR_W-1:0] xa [8] = '{24'h05_0000, 24'hFE_0000, 24'hF0_0000,
      24'h00_0040, 24'h00_1C00, 24'h80_0000, 24'hC0_0000, 24'hE0_0000};
   logic [5:0] xt [8] = '{TGT_EXT, TGT_ROM, TGT_EXT, TGT_MMR, TGT_IO,
      TGT_EXT, TGT_EXT, TGT_EXT};
   logic [5:0] xs [8] = '{6'h1F, 6'h3F, 6'h37, 6'h3F, 6'h3F, 6'h3E,
      6'h3D, 6'h3B};

   always #5 sys_clk = ~sys_clk;

   mmd_memory_map_decoder i_dut (.sys_clk, .rst, .soft_rst, .m_req,
      .m_we, .m_dbl, .m_io, .m_addr, .m_wdata, .m_stall, .m_rvalid,
      .m_rdata, .cpu_status_word_three_we(swe), .rom_disable_bit_in(rin),
      .rom_disable_bit(rbit), .xp_req, .xp_we(), .xp_dbl(), .xp_tgt,
      .xp_addr(xp_a), .xp_wdata(), .xp_rdata, .sdram_pair_mode(pair),
      .ext_bus_8bit(bus8), .ext_addr(ext_a), .sdram_region_select_n(sd_n),
      .sdram_pair_select_n(pr_n), .ext_region_select_n(cs_n));
   mmd_xp_model i_xp (.sys_clk, .xp_req, .xp_tgt, .xp_rdata);

   ////////////////////////////////////////////////////////////
   task automatic chk(logic [DATA_W-1:0] got, logic [DATA_W-1:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("counts: %0d compared, %0d wrong", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   // Hold a request until an edge takes it; a read notes its answer.
   // Stall is sampled at the falling edge, where it has settled.
   task automatic acc(int m, bit we, bit dbl, bit io,
         logic [ADDR_W-1:0] ad, logic [DATA_W-1:0] v);
      bit tk;
      m_req[m] = 1'b1;
      m_we[m] = we;
      m_dbl[m] = dbl;
      m_io[m] = io;
      m_addr[m] = ad;
      m_wdata[m] = v;
      tk = 1'b0;
      for (int n = 0; n < 20 && !tk; n++) begin
         @(negedge sys_clk);
         tk = (m_stall[m] === 1'b0);
         @(posedge sys_clk);
      end
      chk(32'(tk), 32'h1);
      if (tk && !we)
         eq[m].push_back(v);
      #1;
   endtask
   // Drop a request; the edge passed keeps a held read from repeating
   task automatic rel(int m);
      m_req[m] = 1'b0;
      tick();
   endtask
   task automatic endtest(string nm);
      repeat (4) tick();
      for (int i = 0; i < NM; i++)
         chk(32'(eq[i].size()), 32'h0);
      $display("test %s finished", nm);
   endtask

   // Answers are matched to the oldest note of their master
   always @(negedge sys_clk) begin
      for (int i = 0; i < NM; i++) begin
         if (m_rvalid[i] === 1'b1) begin
            chk(32'(eq[i].size() > 0), 32'h1);
            if (eq[i].size() > 0)
               chk(m_rdata[i], eq[i].pop_front());
         end
      end
   end

   // About forty times the expected length of the run
   initial begin
      #100000;
      n_fail++;
      conclude();
   end

   initial begin
      rst = 1'b1;
      {soft_rst, swe, rin, pair, bus8} = '0;
      {m_req, m_we, m_dbl, m_io} = '0;
      for (int i = 0; i < NM; i++) begin
         m_addr[i] = '0;
         m_wdata[i] = '0;
      end
      repeat (20) tick();
      rst = 1'b0;
      tick();
      // Dual RAM: word and high lane from core, read back via DMA
      for (int b = 0; b < 8; b++) begin
         a = ADDR_W'(b * 32'h2000 + 32'h100);
         d = $random(seed);
         acc(M_DWR, 1, 1, 0, a, d);
         acc(M_DWR, 1, 0, 0, a + 2, {16'h0, ~d[15:0]});
         rel(M_DWR);
         acc(M_DMA, 0, 1, 0, a + DMA_DUAL_OFS, {~d[15:0], d[15:0]});
         rel(M_DMA);
         acc(M_PROG, 0, 0, 0, a + 2, {16'h0, ~d[15:0]});
         rel(M_PROG);
      end
      endtest("dual");
      // Single RAM: all 24 blocks, read back by the USB master
      for (int b = 0; b < 24; b++) begin
         a = SING_BASE + ADDR_W'(b) * 24'h00_2000 + ADDR_W'(4 * b);
         d = $random(seed);
         acc(M_DWR, 1, 1, 0, a, d);
         rel(M_DWR);
         acc(M_USB, 0, 1, 0, a + DMA_SING_OFS, d);
         rel(M_USB);
      end
      endtest("single");
      // Unmapped places read zero; a USB write to dual RAM is dropped
      d = $random(seed);
      acc(M_DWR, 1, 1, 0, 24'h00_1000, d);
      rel(M_DWR);
      acc(M_USB, 1, 1, 0, 24'h01_1000, ~d);
      acc(M_USB, 0, 1, 0, 24'h01_1000, 32'h0);
      rel(M_USB);
      acc(M_DMA, 0, 1, 0, 24'h01_1000, d);
      acc(M_DMA, 0, 1, 0, 24'h0C_8000, 32'h0);
      rel(M_DMA);
      acc(M_DRD, 0, 1, 0, 24'h04_0000, 32'h0);
      acc(M_DRD, 0, 0, 0, 24'h04_FFFE, 32'h0);
      rel(M_DRD);
      endtest("unmapped");
      // Two masters in one cycle: dual block serves both, single one
      fork
         begin acc(M_DRD, 0, 1, 0, 24'h00_1000, d); rel(M_DRD); end
         begin acc(M_DMA, 0, 1, 0, 24'h01_1000, d); rel(M_DMA); end
      join
      d = $random(seed);
      acc(M_DWR, 1, 1, 0, 24'h02_4008, d);
      rel(M_DWR);
      fork
         begin acc(M_DRD, 0, 1, 0, 24'h02_4008, d); rel(M_DRD); end
         begin acc(M_DMA, 0, 1, 0, 24'h0A_4008, d); rel(M_DMA); end
      join
      endtest("contention");
      // Shared port: each target and each chip-select space
      for (int i = 0; i < 8; i++) begin
         xm = (i < 4) ? M_DRD : M_PROG;
         acc(xm, 0, 1, i == 4, xa[i], {8'h5A, 18'h0, xt[i]});
         chk(32'({xp_req, xp_tgt, sd_n, pr_n, cs_n}),
            32'({1'b1, xt[i], xs[i]}));
         chk(32'(xp_a), 32'(xa[i]));
         rel(xm);
      end
      {pair, bus8} = 2'h3;
      acc(M_DRD, 0, 1, 0, 24'h05_1234, {8'h5A, 18'h0, TGT_EXT});
      chk(32'({ext_a, 2'h0, sd_n, pr_n, cs_n}), 32'h0012_340F);
      rel(M_DRD);
      {pair, bus8} = 2'h0;
      endtest("shared port");
      // ROM removed by the status bit, kept over soft reset
      swe = 1'b1;
      rin = 1'b1;
      tick();
      swe = 1'b0;
      tick();
      chk(32'(rbit), 32'h1);
      acc(M_DRD, 0, 1, 0, 24'hFF_FFFC, 32'h0);
      chk(32'(xp_req), 32'h0);
      rel(M_DRD);
      soft_rst = 1'b1;
      tick();
      soft_rst = 1'b0;
      tick();
      chk(32'(rbit), 32'h1);
      rst = 1'b1;
      tick();
      rst = 1'b0;
      tick();
      chk(32'(rbit), 32'h0);
      acc(M_PROG, 0, 1, 0, 24'hFE_0000, {8'h5A, 18'h0, TGT_ROM});
      rel(M_PROG);
      endtest("rom bit");
      conclude();
   end
endmodule // test_memory_map_decoder
